// ===== common/twsw_cfg.svh
// constants of the twilight switch-over and manual override block
`ifndef TWSW_CFG_SVH
`define TWSW_CFG_SVH
`define TWSW_ADDR_CTRL 4'h0
`define TWSW_ADDR_TWCFG 4'h1
`define TWSW_ADDR_TWACT 4'h2
`define TWSW_ADDR_BRIGHT 4'h3
`define TWSW_ADDR_EVENT 4'h4
`define TWSW_ADDR_STATUS 4'h5
`define TWSW_ADDR_TIMES 4'h6
`define TWSW_ADDR_OFFTHR 4'h7
`define TWSW_CTRL_RST 16'h0000
`define TWSW_TWCFG_RST 16'h0100
`define TWSW_TIMES_RST 16'h0404
`define TWSW_OFFTHR_RST 16'h0200
`define TWSW_EV_DOWNLOAD 0
`define TWSW_EV_PRESET 1
`define TWSW_EV_TEACH 2
`define TWSW_EV_DEACT 3
`define TWSW_EV_DEACT_VAL 4
`define TWSW_EV_MANUAL 5
`define TWSW_EV_MANUAL_VAL 6
`define TWSW_EV_MOTION 7
`define TWSW_TICK_NS 1000
`define TWSW_CLK_NS 4
`define TWSW_TICK_CYC ((`TWSW_TICK_NS + `TWSW_CLK_NS - 1) / `TWSW_CLK_NS)
`endif

// ===== common/twsw_pkg.sv
// types of the twilight switch-over and manual override block
package twsw_pkg;
	typedef enum logic [1:0] {
		TWSW_SINGLE,
		TWSW_MAIN,
		TWSW_EXT
	} twsw_devtype_t;
	typedef enum logic [1:0] {
		TWSW_FULL_AUTO,
		TWSW_SEMI_1,
		TWSW_MANUAL_ON_MANUAL_OFF
	} twsw_mode_t;
	typedef enum logic [1:0] {
		TWSW_CEILING,
		TWSW_PRESENCE,
		TWSW_LIGHT_CTRL
	} twsw_app_t;
	typedef struct packed {
		logic overwrite;
		logic bright_dep;
		twsw_app_t app;
		twsw_mode_t mode;
		twsw_devtype_t devtype;
	} twsw_ctrl_t;
	typedef struct packed {
		logic begin_tx;
		logic end_tx;
		logic deact_tx;
		logic deact_val;
		logic light_fwd;
		logic light_val;
	} twsw_out_t;
endpackage : twsw_pkg

// ===== design/twsw_regs.sv
// register port of the block
`timescale 1ns/1ps
`include "twsw_cfg.svh"
module twsw_regs (
	input wire logic clk_i,
	input wire logic rst_b,
	input wire logic [3:0] addr_i,
	input wire logic [15:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [15:0] status_i,
	input wire logic [15:0] twact_i,
	output logic [15:0] rdata_o,
	output logic [15:0] ctrl_o,
	output logic [15:0] twcfg_o,
	output logic [15:0] bright_o,
	output logic [15:0] times_o,
	output logic [15:0] offthr_o,
	output logic [7:0] event_o
);
	wire logic wr_ctrl = wr_i && addr_i == `TWSW_ADDR_CTRL;
	wire logic wr_twcfg = wr_i && addr_i == `TWSW_ADDR_TWCFG;
	wire logic wr_bright = wr_i && addr_i == `TWSW_ADDR_BRIGHT;
	wire logic wr_event = wr_i && addr_i == `TWSW_ADDR_EVENT;
	wire logic wr_times = wr_i && addr_i == `TWSW_ADDR_TIMES;
	wire logic wr_offthr = wr_i && addr_i == `TWSW_ADDR_OFFTHR;
	logic [15:0] rd_next;
	always_comb begin
		case (addr_i)
			`TWSW_ADDR_CTRL: rd_next = ctrl_o;
			`TWSW_ADDR_TWCFG: rd_next = twcfg_o;
			`TWSW_ADDR_TWACT: rd_next = twact_i;
			`TWSW_ADDR_BRIGHT: rd_next = bright_o;
			`TWSW_ADDR_STATUS: rd_next = status_i;
			`TWSW_ADDR_TIMES: rd_next = times_o;
			`TWSW_ADDR_OFFTHR: rd_next = offthr_o;
			default: rd_next = 16'h0000;
		endcase
	end
	always_ff @(posedge clk_i or negedge rst_b) begin
		if (!rst_b) begin
			rdata_o <= 16'h0000;
			ctrl_o <= `TWSW_CTRL_RST;
			twcfg_o <= `TWSW_TWCFG_RST;
			bright_o <= 16'h0000;
			times_o <= `TWSW_TIMES_RST;
			offthr_o <= `TWSW_OFFTHR_RST;
			event_o <= 8'h00;
		end else begin
			rdata_o <= rd_i ? rd_next : 16'h0000;
			if (wr_ctrl) ctrl_o <= wdata_i;
			if (wr_twcfg) twcfg_o <= wdata_i;
			if (wr_bright) bright_o <= wdata_i;
			if (wr_times) times_o <= wdata_i;
			if (wr_offthr) offthr_o <= wdata_i;
			event_o <= wr_event ? wdata_i[7:0] : 8'h00;
		end
	end
endmodule : twsw_regs

// ===== design/twsw_timer.sv
// down-counting delay timer in ticks
`timescale 1ns/1ps
`include "twsw_cfg.svh"
module twsw_timer (
	input wire logic clk_i,
	input wire logic rst_b,
	input wire logic tick_i,
	input wire logic start_i,
	input wire logic stop_i,
	input wire logic [7:0] len_i,
	output logic run_o,
	output logic done_o
);
	logic [7:0] cnt_reg;
	always_ff @(posedge clk_i or negedge rst_b) begin
		if (!rst_b) begin
			cnt_reg <= 8'h00;
			run_o <= 1'b0;
			done_o <= 1'b0;
		end else begin
			done_o <= 1'b0;
			if (stop_i) begin
				run_o <= 1'b0;
			end else if (start_i) begin
				cnt_reg <= (len_i == 8'h00) ? 8'h01 : len_i;
				run_o <= 1'b1;
			end else if (run_o && tick_i) begin
				cnt_reg <= cnt_reg - 8'h01;
				if (cnt_reg == 8'h01) begin
					run_o <= 1'b0;
					done_o <= 1'b1;
				end
			end
		end
	end
endmodule : twsw_timer

// ===== design/twsw_core.sv
// twilight switch-over and manual override of one function block
`timescale 1ns/1ps
`include "twsw_cfg.svh"
// Behaviour
// [R01] download with overwrite set restores configured twilight level
// [R02] download without overwrite keeps preset or taught level
// [R03] configured level used until first preset or teach
// [R04] single device: deactivation object input, 1 disables, 0 enables
// [R05] object-selected independence persists past end of detection until 0
// [R06] main unit: object also output following own twilight evaluation
// [R07] main unit forced independent sends no deactivation telegrams
// [R08] party forcing main unit also forces all extensions; the core sends the extensions nothing for this, a forced main only goes silent
// [R09] extension: deactivation object input only, 1 disables, 0 enables
// [R10] one-bit manual lighting object processed in single and main types
// [R11] fully automatic manual on forces begin, presence, transmission delay
// [R12] ceiling: end telegrams on delay expiry, motion restarts delay
// [R13] presence: brightness above switch-off threshold ends after off delay
// [R14] fully automatic manual off sends end, clears, lockout follows
// [R15] semi-auto I manual on enables detection, disabled after end
// [R16] semi-auto I manual off ends, clears and disables detection
// [R17] manual-on-manual-off: no delay, ends only on manual off
// [R18] light control: manual value forwarded and presence started
// [R19] brightness-dependent: motion accepted only below effective level
// [R20] teach stores current brightness as new twilight level
// [R21] deactivation flag changes only on deactivation telegrams
module twsw_core (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic [3:0] addr_i,
	input wire logic [15:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [15:0] rdata_o,
	output twsw_pkg::twsw_out_t tel_o
);
	// ------------------------------------------------------------------
	// reset release
	// ------------------------------------------------------------------
	logic rst_s1_reg;
	logic rst_b;
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rst_s1_reg <= 1'b0;
			rst_b <= 1'b0;
		end else begin
			rst_s1_reg <= 1'b1;
			rst_b <= rst_s1_reg;
		end
	end

	// ------------------------------------------------------------------
	// registers
	// ------------------------------------------------------------------
	logic [15:0] ctrl_w;
	logic [15:0] twcfg_w;
	logic [15:0] bright_w;
	logic [15:0] times_w;
	logic [15:0] offthr_w;
	logic [7:0] ev_w;
	logic [15:0] status_w;
	logic [15:0] twact_reg;
	logic [15:0] rdata_w;
	twsw_regs u_regs (
		.clk_i(clk_i),
		.rst_b(rst_b),
		.addr_i(addr_i),
		.wdata_i(wdata_i),
		.wr_i(wr_i),
		.rd_i(rd_i),
		.status_i(status_w),
		.twact_i(twact_reg),
		.rdata_o(rdata_w),
		.ctrl_o(ctrl_w),
		.twcfg_o(twcfg_w),
		.bright_o(bright_w),
		.times_o(times_w),
		.offthr_o(offthr_w),
		.event_o(ev_w)
	);
	assign rdata_o = rdata_w;
	twsw_pkg::twsw_ctrl_t ctrl;
	assign ctrl = twsw_pkg::twsw_ctrl_t'(ctrl_w[7:0]);

	function automatic logic is_type(input twsw_pkg::twsw_devtype_t t,
		input twsw_pkg::twsw_devtype_t want);
		is_type = (t == want);
	endfunction : is_type

	wire logic ev_download = ev_w[`TWSW_EV_DOWNLOAD];
	wire logic ev_preset = ev_w[`TWSW_EV_PRESET];
	wire logic ev_teach = ev_w[`TWSW_EV_TEACH];
	wire logic ev_deact = ev_w[`TWSW_EV_DEACT];
	wire logic ev_deact_val = ev_w[`TWSW_EV_DEACT_VAL];
	wire logic ev_motion_raw = ev_w[`TWSW_EV_MOTION];
	wire logic man_type = !is_type(ctrl.devtype, twsw_pkg::TWSW_EXT);
	wire logic ev_man = ev_w[`TWSW_EV_MANUAL] && man_type; // R10
	wire logic man_on = ev_man && ev_w[`TWSW_EV_MANUAL_VAL];
	wire logic man_off = ev_man && !ev_w[`TWSW_EV_MANUAL_VAL];
	wire logic is_main = is_type(ctrl.devtype, twsw_pkg::TWSW_MAIN);
	wire logic lc_app = ctrl.app == twsw_pkg::TWSW_LIGHT_CTRL;

	// ------------------------------------------------------------------
	// twilight level source
	// ------------------------------------------------------------------
	logic ext_valid_reg;
	logic [15:0] ext_level_reg;
	always_ff @(posedge clk_i or negedge rst_b) begin
		if (!rst_b) begin
			ext_valid_reg <= 1'b0;
			ext_level_reg <= 16'h0000;
		end else if (ev_teach) begin
			ext_valid_reg <= 1'b1; // R20
			ext_level_reg <= bright_w; // R20
		end else if (ev_preset) begin
			ext_valid_reg <= 1'b1;
			ext_level_reg <= wdata_i;
		end else if (ev_download && ctrl.overwrite) begin
			ext_valid_reg <= 1'b0; // R01
		end
	end
	// download without overwrite leaves the stored level untouched
	wire logic [15:0] level_w = ext_valid_reg ? ext_level_reg : twcfg_w; // R02 R03
	always_ff @(posedge clk_i or negedge rst_b) begin
		if (!rst_b) begin
			twact_reg <= 16'h0000;
		end else begin
			twact_reg <= level_w;
		end
	end

	// ------------------------------------------------------------------
	// twilight deactivation object
	// ------------------------------------------------------------------
	logic deact_reg;
	always_ff @(posedge clk_i or negedge rst_b) begin
		if (!rst_b) begin
			deact_reg <= 1'b0;
		end else if (ev_deact) begin
			deact_reg <= ev_deact_val; // R04 R09 R21
		end
	end
	// deact_reg is untouched by detection end, so independence persists
	wire logic indep = deact_reg || !ctrl.bright_dep || lc_app; // R05
	wire logic dark = bright_w < twact_reg;
	wire logic motion_ok = ev_motion_raw && (indep || dark); // R19

	// ------------------------------------------------------------------
	// tick and timers
	// ------------------------------------------------------------------
	logic [7:0] tick_cnt_reg;
	wire logic tick = tick_cnt_reg == 8'(`TWSW_TICK_CYC - 1);
	always_ff @(posedge clk_i or negedge rst_b) begin
		if (!rst_b) begin
			tick_cnt_reg <= 8'h00;
		end else begin
			tick_cnt_reg <= tick ? 8'h00 : tick_cnt_reg + 8'h01;
		end
	end

	typedef enum logic [1:0] {
		TWSW_IDLE,
		TWSW_ACTIVE,
		TWSW_LOCK
	} twsw_state_t;
	twsw_state_t state_reg;
	twsw_state_t state_next;
	logic det_en_reg;
	logic hold_reg;

	wire logic is_semi1 = ctrl.mode == twsw_pkg::TWSW_SEMI_1;
	wire logic is_mom = ctrl.mode == twsw_pkg::TWSW_MANUAL_ON_MANUAL_OFF;
	wire logic active = state_reg == TWSW_ACTIVE;
	wire logic det_allowed = !is_semi1 || det_en_reg;
	wire logic man_start = man_on || (ev_man && lc_app); // R18
	wire logic man_end = man_off && !lc_app;
	wire logic start_det = man_start || (motion_ok && det_allowed && state_reg == TWSW_IDLE);
	wire logic retrig = active && motion_ok && !hold_reg;
	wire logic tx_start = (man_on && !is_mom) || retrig || (start_det && !man_on); // R11 R12
	logic tx_done;
	logic tx_run;
	logic off_done;
	logic off_run;
	logic lock_done;
	logic lock_run;
	wire logic bright_hi = bright_w > offthr_w;
	wire logic pres_app = ctrl.app == twsw_pkg::TWSW_PRESENCE;
	wire logic off_arm = active && pres_app && !indep && bright_hi && ev_motion_raw && !hold_reg;
	wire logic end_det = active && (man_end || tx_done || off_done);
	wire logic [7:0] lock_len = man_end ? times_w[15:8] : 8'h01;

	twsw_timer u_tx (
		.clk_i(clk_i),
		.rst_b(rst_b),
		.tick_i(tick),
		.start_i(tx_start),
		.stop_i(man_end || !active && !start_det || man_on && is_mom),
		.len_i(times_w[7:0]),
		.run_o(tx_run),
		.done_o(tx_done)
	);
	twsw_timer u_off (
		.clk_i(clk_i),
		.rst_b(rst_b),
		.tick_i(tick),
		.start_i(off_arm && !off_run), // R13
		.stop_i(!active || !bright_hi || hold_reg),
		.len_i(times_w[7:0]),
		.run_o(off_run),
		.done_o(off_done)
	);
	twsw_timer u_lock (
		.clk_i(clk_i),
		.rst_b(rst_b),
		.tick_i(tick),
		.start_i(end_det), // R14
		.stop_i(1'b0),
		.len_i(lock_len),
		.run_o(lock_run),
		.done_o(lock_done)
	);

	// ------------------------------------------------------------------
	// detection state
	// ------------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			TWSW_IDLE: if (start_det) state_next = TWSW_ACTIVE;
			TWSW_ACTIVE: if (end_det) state_next = TWSW_LOCK; // R14 R17
			TWSW_LOCK: if (man_start) state_next = TWSW_ACTIVE;
				else if (lock_done) state_next = TWSW_IDLE;
			default: state_next = TWSW_IDLE;
		endcase
	end
	always_ff @(posedge clk_i or negedge rst_b) begin
		if (!rst_b) begin
			state_reg <= TWSW_IDLE;
			det_en_reg <= 1'b0;
			hold_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			if (man_on) det_en_reg <= 1'b1; // R15
			else if (end_det && is_semi1) det_en_reg <= 1'b0; // R15 R16
			if (man_on) hold_reg <= is_mom; // R17
			else if (end_det) hold_reg <= 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// telegram outputs
	// ------------------------------------------------------------------
	wire logic begin_ev = (state_reg != TWSW_ACTIVE) && state_next == TWSW_ACTIVE;
	wire logic deact_out_ok = is_main && !deact_reg; // R06 R07
	always_ff @(posedge clk_i or negedge rst_b) begin
		if (!rst_b) begin
			tel_o <= '0;
		end else begin
			tel_o.begin_tx <= begin_ev || (man_on && active); // R11
			tel_o.end_tx <= end_det; // R12 R14 R16
			tel_o.deact_tx <= deact_out_ok && (begin_ev || end_det); // R06
			tel_o.deact_val <= deact_out_ok ? begin_ev : tel_o.deact_val;
			tel_o.light_fwd <= ev_man && lc_app; // R18
			tel_o.light_val <= (ev_man && lc_app) ? man_on : tel_o.light_val;
		end
	end
	assign status_w = {9'h000, lock_run, tx_run, det_en_reg, hold_reg, deact_reg,
		ext_valid_reg, active};

	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	deact_follow_a: assert property (@(posedge clk_i) disable iff (!rst_b) // R04
		ev_deact |=> deact_reg == $past(ev_deact_val)) else $error("deact flag wrong");
	deact_hold_a: assert property (@(posedge clk_i) disable iff (!rst_b) // R21
		!ev_deact |=> $stable(deact_reg)) else $error("deact flag moved");
	dl_restore_a: assert property (@(posedge clk_i) disable iff (!rst_b) // R01
		ev_download && ctrl.overwrite && !ev_teach && !ev_preset |=> !ext_valid_reg)
		else $error("download kept level");
	dl_keep_a: assert property (@(posedge clk_i) disable iff (!rst_b) // R02
		ev_download && !ctrl.overwrite && ext_valid_reg |=> ext_valid_reg)
		else $error("download lost level");
	teach_store_a: assert property (@(posedge clk_i) disable iff (!rst_b) // R20
		ev_teach |=> ext_level_reg == $past(bright_w)) else $error("teach missed");
	man_on_a: assert property (@(posedge clk_i) disable iff (!rst_b) // R11
		man_on |=> tel_o.begin_tx) else $error("manual on no begin");
	man_off_a: assert property (@(posedge clk_i) disable iff (!rst_b) // R14
		man_end && active |=> tel_o.end_tx ##0 state_reg == TWSW_LOCK)
		else $error("manual off no end");
	semi_dis_a: assert property (@(posedge clk_i) disable iff (!rst_b) // R16
		man_end && active && is_semi1 |=> !det_en_reg) else $error("semi I not disabled");
	mom_hold_a: assert property (@(posedge clk_i) disable iff (!rst_b) // R17
		man_on && is_mom |=> !tx_run) else $error("delay started");
	main_mute_a: assert property (@(posedge clk_i) disable iff (!rst_b) // R07
		deact_reg |=> !tel_o.deact_tx) else $error("muted main sent");
	lc_fwd_a: assert property (@(posedge clk_i) disable iff (!rst_b) // R18
		ev_man && lc_app |=> tel_o.light_fwd ##0 active) else $error("no forward");
	dark_gate_a: assert property (@(posedge clk_i) disable iff (!rst_b) // R19
		state_reg == TWSW_IDLE && !ev_man && ev_motion_raw && !indep && !dark
		|=> state_reg == TWSW_IDLE) else $error("bright motion taken");
	tx_start_a: assert property (@(posedge clk_i) disable iff (!rst_b) // R11
		man_on && !is_mom |=> tx_run) else $error("delay not started");
	ceil_end_a: assert property (@(posedge clk_i) disable iff (!rst_b) // R12
		tx_done && active |=> tel_o.end_tx) else $error("no end on delay expiry");
	retrig_a: assert property (@(posedge clk_i) disable iff (!rst_b) // R12
		retrig && !ev_man |=> tx_run) else $error("motion did not restart delay");
	off_arm_a: assert property (@(posedge clk_i) disable iff (!rst_b) // R13
		off_arm && !off_run |=> off_run) else $error("switch-off delay not armed");
	off_end_a: assert property (@(posedge clk_i) disable iff (!rst_b) // R13
		off_done && active |=> tel_o.end_tx) else $error("no end after switch-off delay");
	lock_quiet_a: assert property (@(posedge clk_i) disable iff (!rst_b) // R14
		state_reg == TWSW_LOCK && !ev_man |=> !tel_o.begin_tx)
		else $error("detection during lockout");
	semi_en_a: assert property (@(posedge clk_i) disable iff (!rst_b) // R15
		man_on && is_semi1 |=> det_en_reg) else $error("semi I not enabled");
	semi_auto_a: assert property (@(posedge clk_i) disable iff (!rst_b) // R15
		tx_done && active && is_semi1 && !man_on |=> !det_en_reg)
		else $error("semi I stays enabled");
	mom_stay_a: assert property (@(posedge clk_i) disable iff (!rst_b) // R17
		active && hold_reg && is_mom && !lc_app && !ev_man |=> active)
		else $error("held detection ended");
	deact_out_a: assert property (@(posedge clk_i) disable iff (!rst_b) // R06
		is_main && !deact_reg && begin_ev |=> tel_o.deact_tx && tel_o.deact_val)
		else $error("main did not drive extensions");
	ext_silent_a: assert property (@(posedge clk_i) disable iff (!rst_b) // R09
		!is_main |=> !tel_o.deact_tx) else $error("deactivation sent by non-main");
	ext_manual_a: assert property (@(posedge clk_i) disable iff (!rst_b) // R10
		ev_w[`TWSW_EV_MANUAL] && !man_type |=> !tel_o.light_fwd)
		else $error("extension took manual");
	preset_load_a: assert property (@(posedge clk_i) disable iff (!rst_b) // R03
		ev_preset && !ev_teach |=> ext_valid_reg && ext_level_reg == $past(wdata_i))
		else $error("preset not taken");
	level_cfg_a: assert property (@(posedge clk_i) disable iff (!rst_b) // R03
		!ext_valid_reg |=> twact_reg == $past(twcfg_w)) else $error("configured level unused");
	indep_keep_a: assert property (@(posedge clk_i) disable iff (!rst_b) // R05
		deact_reg && end_det && !ev_deact |=> deact_reg) else $error("independence dropped");
	lc_val_a: assert property (@(posedge clk_i) disable iff (!rst_b) // R18
		ev_man && lc_app |=> tel_o.light_val == $past(man_on)) else $error("wrong forward value");
	cov_on_c: cover property (@(posedge clk_i) man_on ##1 tel_o.begin_tx);
	cov_end_c: cover property (@(posedge clk_i) tx_done ##1 tel_o.end_tx);
	cov_off_c: cover property (@(posedge clk_i) off_done);
	cov_deact_c: cover property (@(posedge clk_i) ev_deact && ev_deact_val);
	cov_semi_c: cover property (@(posedge clk_i) man_on && is_semi1);
endmodule : twsw_core

// ===== verification/twsw_peer.sv
// far-side model: telegram listener and one extension detector
`timescale 1ns/1ps
module twsw_peer (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire twsw_pkg::twsw_out_t tel_i,
	input wire logic force_i,
	output logic [7:0] n_begin_o,
	output logic [7:0] n_end_o,
	output logic [7:0] n_deact_o,
	output logic ext_indep_o,
	output logic light_o
);
	// ----------------------------------------
	// telegram counters and extension state
	// ----------------------------------------
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			n_begin_o <= 8'h00;
			n_end_o <= 8'h00;
			n_deact_o <= 8'h00;
			ext_indep_o <= 1'b0;
			light_o <= 1'b0;
		end else begin
			n_begin_o <= n_begin_o + {7'h00, tel_i.begin_tx};
			n_end_o <= n_end_o + {7'h00, tel_i.end_tx};
			n_deact_o <= n_deact_o + {7'h00, tel_i.deact_tx};
			if (force_i) begin
				ext_indep_o <= 1'b1;
			end else if (tel_i.deact_tx) begin
				ext_indep_o <= tel_i.deact_val;
			end
			if (tel_i.light_fwd) begin
				light_o <= tel_i.light_val;
			end
		end
	end
endmodule : twsw_peer

// ===== verification/twsw_core_test.sv
// self-checking bench of the twilight switch-over block
`timescale 1ns/1ps
`include "twsw_cfg.svh"
module twsw_core_test;
	logic clk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic [3:0] addr_i = 4'h0;
	logic [15:0] wdata_i = 16'h0000;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic force_i = 1'b0;
	logic [15:0] rdata_o;
	twsw_pkg::twsw_out_t tel_o;
	logic [7:0] n_begin, n_end, n_deact, b0, e0, x0;
	logic ext_indep, light_on;
	int error_cnt = 0;
	int n_tests = 0;

	always #2 clk_i = ~clk_i;

	twsw_core twsw_core_inst (.clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .tel_o(tel_o));
	twsw_peer twsw_peer_inst (.clk_i(clk_i), .rst_b_i(rst_b_i), .tel_i(tel_o),
		.force_i(force_i), .n_begin_o(n_begin), .n_end_o(n_end), .n_deact_o(n_deact),
		.ext_indep_o(ext_indep), .light_o(light_on));

	// ----------------------------------------
	// access and compare tasks
	// ----------------------------------------
	task automatic wr(input logic [3:0] a, input logic [15:0] v);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= v;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask : wr

	task automatic ev(input logic [15:0] bits, input logic [15:0] lvl);
		wr(`TWSW_ADDR_EVENT, bits);
		wdata_i <= lvl;
		repeat (4) @(posedge clk_i);
		#1;
	endtask : ev

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic rchk(input logic [3:0] a, input logic [15:0] m, input logic [15:0] exp);
		logic [15:0] v;
		@(posedge clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1 v = rdata_o;
		chk(v & m, exp);
	endtask : rchk

	task automatic st(input int b, input logic e);
		rchk(`TWSW_ADDR_STATUS, 16'h0001 << b, {15'h0000, e} << b);
	endtask : st

	task automatic snap();
		b0 = n_begin;
		e0 = n_end;
		x0 = n_deact;
	endtask : snap

	task automatic cnt(input logic [7:0] db, input logic [7:0] de);
		chk({8'h00, n_begin}, {8'h00, b0 + db});
		chk({8'h00, n_end}, {8'h00, e0 + de});
	endtask : cnt

	task automatic tk(input int halves);
		repeat (halves * `TWSW_TICK_CYC / 2) @(posedge clk_i);
		#1;
	endtask : tk

	task automatic rst_pulse();
		@(posedge clk_i);
		rst_b_i <= 1'b0;
		repeat (16) @(posedge clk_i);
		rst_b_i <= 1'b1;
		repeat (4) @(posedge clk_i);
	endtask : rst_pulse

	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : end_sim

	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		repeat (16) @(posedge clk_i);
		rst_b_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		rchk(`TWSW_ADDR_CTRL, 16'hffff, `TWSW_CTRL_RST);
		rchk(`TWSW_ADDR_TWCFG, 16'hffff, `TWSW_TWCFG_RST);
		rchk(`TWSW_ADDR_TIMES, 16'hffff, `TWSW_TIMES_RST);
		rchk(`TWSW_ADDR_OFFTHR, 16'hffff, `TWSW_OFFTHR_RST);
		wr(4'h9, 16'hffff);
		rchk(4'h9, 16'hffff, 16'h0000);
		wr(`TWSW_ADDR_TWACT, 16'h1234);
		rchk(`TWSW_ADDR_TWACT, 16'hffff, 16'h0100);
		rchk(`TWSW_ADDR_EVENT, 16'hffff, 16'h0000);
		ev(16'h0002, 16'h0050);
		rchk(`TWSW_ADDR_TWACT, 16'hffff, 16'h0050);
		st(1, 1'b1);
		ev(16'h0001, 16'h0000);
		rchk(`TWSW_ADDR_TWACT, 16'hffff, 16'h0050);
		wr(`TWSW_ADDR_BRIGHT, 16'h0033);
		ev(16'h0004, 16'h0000);
		rchk(`TWSW_ADDR_TWACT, 16'hffff, 16'h0033);
		wr(`TWSW_ADDR_CTRL, 16'h0080);
		ev(16'h0001, 16'h0000);
		rchk(`TWSW_ADDR_TWACT, 16'hffff, 16'h0100);
		// fully automatic ceiling
		wr(`TWSW_ADDR_CTRL, 16'h0000);
		snap();
		ev(16'h0060, 16'h0000);
		cnt(8'h01, 8'h00);
		st(5, 1'b1);
		tk(4);
		ev(16'h0080, 16'h0000);
		tk(5);
		cnt(8'h01, 8'h00);
		tk(4);
		cnt(8'h01, 8'h01);
		tk(10);
		ev(16'h0060, 16'h0000);
		ev(16'h0020, 16'h0000);
		cnt(8'h02, 8'h02);
		st(0, 1'b0);
		st(6, 1'b1);
		ev(16'h0080, 16'h0000);
		cnt(8'h02, 8'h02);
		tk(10);
		ev(16'h0080, 16'h0000);
		cnt(8'h03, 8'h02);
		tk(20);
		// semi-automatic I
		rst_pulse();
		wr(`TWSW_ADDR_CTRL, 16'h0004);
		snap();
		ev(16'h0080, 16'h0000);
		cnt(8'h00, 8'h00);
		ev(16'h0060, 16'h0000);
		cnt(8'h01, 8'h00);
		st(4, 1'b1);
		tk(10);
		cnt(8'h01, 8'h01);
		st(4, 1'b0);
		ev(16'h0060, 16'h0000);
		ev(16'h0020, 16'h0000);
		cnt(8'h02, 8'h02);
		st(4, 1'b0);
		tk(10);
		ev(16'h0080, 16'h0000);
		cnt(8'h02, 8'h02);
		// manual on, manual off
		wr(`TWSW_ADDR_CTRL, 16'h0008);
		snap();
		ev(16'h0060, 16'h0000);
		cnt(8'h01, 8'h00);
		st(5, 1'b0);
		st(3, 1'b1);
		tk(12);
		cnt(8'h01, 8'h00);
		ev(16'h0020, 16'h0000);
		cnt(8'h01, 8'h01);
		tk(10);
		// presence detector switch-off brightness
		wr(`TWSW_ADDR_CTRL, 16'h0050);
		wr(`TWSW_ADDR_OFFTHR, 16'h0010);
		snap();
		ev(16'h0080, 16'h0000);
		cnt(8'h01, 8'h00);
		wr(`TWSW_ADDR_BRIGHT, 16'h0080);
		ev(16'h0080, 16'h0000);
		tk(4);
		ev(16'h0080, 16'h0000);
		tk(5);
		cnt(8'h01, 8'h01);
		tk(10);
		// single device, deactivation object and brightness
		wr(`TWSW_ADDR_CTRL, 16'h0040);
		wr(`TWSW_ADDR_BRIGHT, 16'hffff);
		ev(16'h0018, 16'h0000);
		st(2, 1'b1);
		snap();
		ev(16'h0080, 16'h0000);
		cnt(8'h01, 8'h00);
		tk(12);
		cnt(8'h01, 8'h01);
		st(2, 1'b1);
		ev(16'h0008, 16'h0000);
		st(2, 1'b0);
		tk(10);
		ev(16'h0080, 16'h0000);
		cnt(8'h01, 8'h01);
		wr(`TWSW_ADDR_BRIGHT, 16'h0000);
		ev(16'h0080, 16'h0000);
		cnt(8'h02, 8'h01);
		tk(22);
		// main unit drives the extension
		wr(`TWSW_ADDR_CTRL, 16'h0041);
		chk({15'h0000, ext_indep}, 16'h0000);
		ev(16'h0080, 16'h0000);
		chk({15'h0000, ext_indep}, 16'h0001);
		tk(22);
		chk({15'h0000, ext_indep}, 16'h0000);
		force_i <= 1'b1;
		ev(16'h0018, 16'h0000);
		snap();
		ev(16'h0080, 16'h0000);
		tk(22);
		chk({8'h00, n_deact}, {8'h00, x0});
		ev(16'h0008, 16'h0000);
		force_i <= 1'b0;
		// extension and light control
		wr(`TWSW_ADDR_CTRL, 16'h0002);
		snap();
		ev(16'h0060, 16'h0000);
		cnt(8'h00, 8'h00);
		ev(16'h0018, 16'h0000);
		st(2, 1'b1);
		ev(16'h0008, 16'h0000);
		st(2, 1'b0);
		wr(`TWSW_ADDR_CTRL, 16'h0020);
		ev(16'h0060, 16'h0000);
		chk({15'h0000, light_on}, 16'h0001);
		st(0, 1'b1);
		ev(16'h0020, 16'h0000);
		chk({15'h0000, light_on}, 16'h0000);
		st(0, 1'b1);
		end_sim();
	end

	initial begin
		#200000;
		error_cnt++;
		end_sim();
	end
endmodule : twsw_core_test
